/* core/tcou_pkg.sv */
`default_nettype none
package tcou_pkg;
  // complete state of the clock output unit
  typedef struct packed {
    logic [7:0] aux;
    logic [7:0] wake;
    logic [7:0] reload;
    logic [3:0] div_cnt;
    logic shift_ph;
    logic [7:0] brt_cnt;
    logic t0_lat;
    logic t1_lat;
    logic brt_lat;
    logic t0_pin;
    logic t1_pin;
    logic rd_ack;
    logic [7:0] rdata;
  } tcou_state_t;
endpackage
`default_nettype wire

/* core/tcou_regs.svh */
`ifndef TCOU_REGS_SVH
`define TCOU_REGS_SVH
// register indices; byte address is four times the index
`define TCOU_AUX_IDX 8'h8E
`define TCOU_WAKE_IDX 8'h8F
`define TCOU_RELOAD_IDX 8'h9C
// auxiliary control field positions
`define TCOU_T0_X1_BIT 7
`define TCOU_T1_X1_BIT 6
`define TCOU_U1_M0_BIT 5
`define TCOU_BRT_RUN_BIT 4
`define TCOU_U2_DBL_BIT 3
`define TCOU_BRT_X1_BIT 2
`define TCOU_XRAM_BIT 1
`define TCOU_U1_SRC_BIT 0
// wake and clock-out control field positions
`define TCOU_CAP_WAKE_BIT 7
`define TCOU_RXD_WAKE_BIT 6
`define TCOU_T1_WAKE_BIT 5
`define TCOU_T0_WAKE_BIT 4
`define TCOU_LV_WAKE_BIT 3
`define TCOU_BRT_CLKO_BIT 2
`define TCOU_T1_CLKO_BIT 1
`define TCOU_T0_CLKO_BIT 0
// reset values
`define TCOU_AUX_RST 8'h00
`define TCOU_WAKE_RST 8'h00
`define TCOU_RELOAD_RST 8'h00
// prescale counts in system clocks
`define TCOU_DIV_SLOW 12
`define TCOU_DIV_SHIFT 2
// top of on-chip auxiliary ram window
`define TCOU_XRAM_TOP 16'h03FF
`endif

/* core/tcou_top.sv */
// The Avalon-MM slave port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "tcou_regs.svh"
module tcou_top #(
  parameter int DIV_SLOW = `TCOU_DIV_SLOW,
  parameter int DIV_SHIFT = `TCOU_DIV_SHIFT
) (
  // clock and reset
  input wire logic I_CORE_CLK,
  input wire logic I_RST_N,
  // avalon-mm slave
  input wire logic [9:0] I_ADDRESS,
  input wire logic I_READ,
  input wire logic I_WRITE,
  input wire logic [3:0] I_BYTEENABLE,
  input wire logic [31:0] I_WRITEDATA,
  output logic [31:0] O_READDATA,
  output logic O_WAITREQUEST,
  // timer cores
  input wire logic I_T0_OVF,
  input wire logic I_T1_OVF,
  input wire logic I_T0_COUNTER_MODE,
  input wire logic I_T1_COUNTER_MODE,
  input wire logic I_T0_PIN,
  input wire logic I_T1_PIN,
  output logic O_T0_COUNT_EN,
  output logic O_T1_COUNT_EN,
  // uart rate control
  output logic O_UART1_SHIFT_TICK,
  output logic O_UART1_BAUD_TICK,
  output logic O_UART2_RATE_DOUBLE,
  output logic O_BRT_OVF,
  // auxiliary ram steering
  input wire logic [15:0] I_XRAM_ADDR,
  output logic O_XRAM_ONCHIP,
  output logic O_XRAM_OFFCHIP,
  // wake sources
  input wire logic I_CAP_ACT,
  input wire logic I_CAP_IRQ_CFG,
  input wire logic I_RXD_ACT,
  input wire logic I_RXD_IRQ_CFG,
  input wire logic I_T1_ACT,
  input wire logic I_T1_IRQ_CFG,
  input wire logic I_T0_ACT,
  input wire logic I_T0_IRQ_CFG,
  input wire logic I_LV_ACT,
  input wire logic I_LV_IRQ_CFG,
  output logic O_WAKE,
  // clock output pins
  output logic O_T0_CLK_OUT,
  output logic O_T0_CLK_OE,
  output logic O_T1_CLK_OUT,
  output logic O_T1_CLK_OE,
  output logic O_BRT_CLK_OUT,
  output logic O_BRT_CLK_OE
);

  // ----------------------------------------
  // elaboration checks
  // ----------------------------------------
  if (DIV_SLOW < 2 || DIV_SLOW > 16) begin : g_bad_slow
    $error("DIV_SLOW must lie in 2..16");
  end
  if (DIV_SHIFT < 1 || DIV_SHIFT > 2) begin : g_bad_shift
    $error("DIV_SHIFT must be 1 or 2");
  end

  localparam logic [3:0] DIV_LAST = 4'(DIV_SLOW - 1);
  localparam logic [9:0] AUX_ADDR = {`TCOU_AUX_IDX, 2'b00};
  localparam logic [9:0] WAKE_ADDR = {`TCOU_WAKE_IDX, 2'b00};
  localparam logic [9:0] RELOAD_ADDR = {`TCOU_RELOAD_IDX, 2'b00};

  tcou_pkg::tcou_state_t s_q, s_d;

  // ----------------------------------------
  // decoded controls and ticks
  // ----------------------------------------
  logic slow_tick, t0_tick, t1_tick, brt_tick, brt_ovf;
  logic t0_edge, t1_edge, wr_en;

  // one shared divide-by-12 prescaler feeds all slow clocks
  assign slow_tick = (s_q.div_cnt == DIV_LAST);
  assign t0_tick = s_q.aux[`TCOU_T0_X1_BIT] | slow_tick;
  assign t1_tick = s_q.aux[`TCOU_T1_X1_BIT] | slow_tick;
  assign brt_tick = s_q.aux[`TCOU_BRT_RUN_BIT] & (s_q.aux[`TCOU_BRT_X1_BIT] | slow_tick);
  assign brt_ovf = brt_tick & (s_q.brt_cnt == 8'hFF);
  // falling edges on the external timer pins
  assign t0_edge = s_q.t0_pin & ~I_T0_PIN;
  assign t1_edge = s_q.t1_pin & ~I_T1_PIN;
  // writes use only the low byte lane
  assign wr_en = I_WRITE & I_BYTEENABLE[0];

  // ----------------------------------------
  // next state
  // ----------------------------------------
  // single process computes every next value
  always_comb begin
    s_d = s_q;
    s_d.t0_pin = I_T0_PIN;
    s_d.t1_pin = I_T1_PIN;
    // free running prescaler, wraps at the slow divide
    s_d.div_cnt = slow_tick ? 4'h0 : s_q.div_cnt + 4'h1;
    // mode-0 shift phase only matters for divide by two
    s_d.shift_ph = ~s_q.shift_ph;
    if (brt_ovf) begin
      s_d.brt_cnt = s_q.reload;
    end else if (brt_tick) begin
      s_d.brt_cnt = s_q.brt_cnt + 8'h01;
    end
    // timer0 latch toggles only when enabled
    if (I_T0_OVF && s_q.wake[`TCOU_T0_CLKO_BIT]) begin
      s_d.t0_lat = ~s_q.t0_lat;
    end
    // timer1 latch toggles only when enabled
    if (I_T1_OVF && s_q.wake[`TCOU_T1_CLKO_BIT]) begin
      s_d.t1_lat = ~s_q.t1_lat;
    end
    // baud latch toggles only when enabled
    if (brt_ovf && s_q.wake[`TCOU_BRT_CLKO_BIT]) begin
      s_d.brt_lat = ~s_q.brt_lat;
    end
    // read takes one wait cycle so data comes from a flop
    s_d.rd_ack = I_READ & ~s_q.rd_ack;
    if (I_READ && !s_q.rd_ack) begin
      unique case (I_ADDRESS)
        AUX_ADDR: s_d.rdata = s_q.aux;
        WAKE_ADDR: s_d.rdata = s_q.wake;
        RELOAD_ADDR: s_d.rdata = s_q.reload;
        default: s_d.rdata = 8'h00;
      endcase
    end
    // writes land immediately; unmapped addresses are dropped
    if (wr_en) begin
      unique case (I_ADDRESS)
        AUX_ADDR: s_d.aux = I_WRITEDATA[7:0];
        WAKE_ADDR: s_d.wake = I_WRITEDATA[7:0];
        RELOAD_ADDR: s_d.reload = I_WRITEDATA[7:0];
        default: s_d.aux = s_q.aux;
      endcase
    end
  end

  always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      s_q <= '{aux: `TCOU_AUX_RST, wake: `TCOU_WAKE_RST, reload: `TCOU_RELOAD_RST,
               default: '0};
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  // bus answer
  assign O_WAITREQUEST = I_READ & ~s_q.rd_ack;
  assign O_READDATA = {24'h000000, s_q.rdata};
  assign O_T0_COUNT_EN = I_T0_COUNTER_MODE ? t0_edge : t0_tick;
  assign O_T1_COUNT_EN = I_T1_COUNTER_MODE ? t1_edge : t1_tick;
  // shift rate: mode 0 divides by two from the phase flop (every clock if DIV_SHIFT is 1), else the slow tick
  assign O_UART1_SHIFT_TICK = s_q.aux[`TCOU_U1_M0_BIT] ?
                              (DIV_SHIFT == 1 ? 1'b1 : s_q.shift_ph) : slow_tick;
  assign O_UART1_BAUD_TICK = s_q.aux[`TCOU_U1_SRC_BIT] ? brt_ovf : I_T1_OVF;
  assign O_UART2_RATE_DOUBLE = s_q.aux[`TCOU_U2_DBL_BIT];
  assign O_BRT_OVF = brt_ovf;
  // on-chip window only while select bit clear
  assign O_XRAM_ONCHIP = ~s_q.aux[`TCOU_XRAM_BIT] & (I_XRAM_ADDR <= `TCOU_XRAM_TOP);
  assign O_XRAM_OFFCHIP = ~O_XRAM_ONCHIP;
  assign O_WAKE = (s_q.wake[`TCOU_CAP_WAKE_BIT] & I_CAP_IRQ_CFG & I_CAP_ACT) |
                  (s_q.wake[`TCOU_RXD_WAKE_BIT] & I_RXD_IRQ_CFG & I_RXD_ACT) |
                  (s_q.wake[`TCOU_T1_WAKE_BIT] & I_T1_IRQ_CFG & I_T1_ACT) |
                  (s_q.wake[`TCOU_T0_WAKE_BIT] & I_T0_IRQ_CFG & I_T0_ACT) |
                  (s_q.wake[`TCOU_LV_WAKE_BIT] & I_LV_IRQ_CFG & I_LV_ACT);
  // three pins, each driven only while its enable is set
  assign O_T0_CLK_OUT = s_q.t0_lat;
  assign O_T1_CLK_OUT = s_q.t1_lat;
  assign O_BRT_CLK_OUT = s_q.brt_lat;
  assign O_T0_CLK_OE = s_q.wake[`TCOU_T0_CLKO_BIT];
  assign O_T1_CLK_OE = s_q.wake[`TCOU_T1_CLKO_BIT];
  assign O_BRT_CLK_OE = s_q.wake[`TCOU_BRT_CLKO_BIT];

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge I_CORE_CLK); endclocking
  default disable iff (!I_RST_N);

  // prescaler period check
  slow_period_a: assert property (slow_tick |=> !slow_tick [*8])
    else $error("slow tick repeated too early");
  // a write may switch to fast in between, so that case is let through
  t1_slow_a: assert property (!s_q.aux[`TCOU_T1_X1_BIT] && t1_tick |=>
                              !t1_tick || s_q.aux[`TCOU_T1_X1_BIT])
    else $error("timer1 slow tick too fast");
  brt_stop_a: assert property (!s_q.aux[`TCOU_BRT_RUN_BIT] |=>
                               s_q.brt_cnt == $past(s_q.brt_cnt))
    else $error("baud timer moved while stopped");
  brt_reload_a: assert property (brt_ovf |=> s_q.brt_cnt == $past(s_q.reload))
    else $error("baud timer did not reload");
  t0_toggle_a: assert property (I_T0_OVF && O_T0_CLK_OE |=>
                                O_T0_CLK_OUT != $past(O_T0_CLK_OUT))
    else $error("timer0 latch not toggled");
  t1_hold_a: assert property (!O_T1_CLK_OE |=> O_T1_CLK_OUT == $past(O_T1_CLK_OUT))
    else $error("timer1 latch moved while disabled");
  brt_toggle_a: assert property (brt_ovf && O_BRT_CLK_OE |=> $changed(O_BRT_CLK_OUT))
    else $error("baud latch not toggled");
  src_sel_a: assert property (s_q.aux[`TCOU_U1_SRC_BIT] |->
                              O_UART1_BAUD_TICK == brt_ovf)
    else $error("uart1 baud source wrong");
  xram_off_a: assert property (s_q.aux[`TCOU_XRAM_BIT] |-> !O_XRAM_ONCHIP)
    else $error("on-chip ram used while disabled");
  wake_gate_a: assert property (s_q.wake[7:3] == 5'h00 |-> !O_WAKE)
    else $error("wake without enable");
  read_wait_a: assert property (I_READ && !s_q.rd_ack |=> !O_WAITREQUEST || !I_READ)
    else $error("read held off too long");

  // writes land at once, the master never stalls
  write_nowait_a: assert property (I_WRITE |-> !O_WAITREQUEST)
    else $error("write held off");

  t0_fast_a: assert property (s_q.aux[`TCOU_T0_X1_BIT] |-> t0_tick)
    else $error("timer0 fast tick missing");

  t0_slow_a: assert property (!s_q.aux[`TCOU_T0_X1_BIT] && t0_tick |=>
                              !t0_tick || s_q.aux[`TCOU_T0_X1_BIT])
    else $error("timer0 slow tick too fast");

  t1_fast_a: assert property (s_q.aux[`TCOU_T1_X1_BIT] |-> t1_tick)
    else $error("timer1 fast tick missing");

  shift_half_a: assert property ((DIV_SHIFT == 2) && s_q.aux[`TCOU_U1_M0_BIT] &&
                                 O_UART1_SHIFT_TICK |=>
                                 !O_UART1_SHIFT_TICK || !s_q.aux[`TCOU_U1_M0_BIT])
    else $error("fast shift tick too fast");

  shift_slow_a: assert property (!s_q.aux[`TCOU_U1_M0_BIT] && O_UART1_SHIFT_TICK |=>
                                 !O_UART1_SHIFT_TICK || s_q.aux[`TCOU_U1_M0_BIT])
    else $error("slow shift tick too fast");

  // fast baud timer steps each clock
  brt_step_a: assert property (s_q.aux[`TCOU_BRT_RUN_BIT] && s_q.aux[`TCOU_BRT_X1_BIT] &&
                               !brt_ovf |=> s_q.brt_cnt == $past(s_q.brt_cnt) + 8'h01)
    else $error("baud timer did not step");

  // overflow only from a running top count
  brt_ovf_top_a: assert property (O_BRT_OVF |->
                                  s_q.brt_cnt == 8'hFF && s_q.aux[`TCOU_BRT_RUN_BIT])
    else $error("baud overflow out of place");

  t1_toggle_a: assert property (I_T1_OVF && O_T1_CLK_OE |=> $changed(O_T1_CLK_OUT))
    else $error("timer1 latch not toggled");

  t0_hold_a: assert property (!O_T0_CLK_OE |=> O_T0_CLK_OUT == $past(O_T0_CLK_OUT))
    else $error("timer0 latch moved while disabled");

  brt_hold_a: assert property (!O_BRT_CLK_OE |=> O_BRT_CLK_OUT == $past(O_BRT_CLK_OUT))
    else $error("baud latch moved while disabled");

  // counter mode counts only with pin low
  t0_count_a: assert property (I_T0_COUNTER_MODE && O_T0_COUNT_EN |-> !I_T0_PIN)
    else $error("timer0 counted without pin edge");

  t1_count_a: assert property (I_T1_COUNTER_MODE && O_T1_COUNT_EN |-> !I_T1_PIN)
    else $error("timer1 counted without pin edge");

  src_t1_a: assert property (!s_q.aux[`TCOU_U1_SRC_BIT] |->
                             O_UART1_BAUD_TICK == I_T1_OVF)
    else $error("uart1 baud not from timer1");

  xram_on_a: assert property (!s_q.aux[`TCOU_XRAM_BIT] &&
                              I_XRAM_ADDR <= `TCOU_XRAM_TOP |-> O_XRAM_ONCHIP)
    else $error("on-chip ram window missed");

  xram_split_a: assert property (O_XRAM_ONCHIP != O_XRAM_OFFCHIP)
    else $error("ram target ambiguous");

  cap_wake_a: assert property (s_q.wake[`TCOU_CAP_WAKE_BIT] && I_CAP_IRQ_CFG &&
                               I_CAP_ACT |-> O_WAKE)
    else $error("capture wake missed");

  rxd_wake_a: assert property (s_q.wake[`TCOU_RXD_WAKE_BIT] && I_RXD_IRQ_CFG &&
                               I_RXD_ACT |-> O_WAKE)
    else $error("receive wake missed");

  t1_wake_a: assert property (s_q.wake[`TCOU_T1_WAKE_BIT] && I_T1_IRQ_CFG &&
                              I_T1_ACT |-> O_WAKE)
    else $error("timer1 wake missed");

  t0_wake_a: assert property (s_q.wake[`TCOU_T0_WAKE_BIT] && I_T0_IRQ_CFG &&
                              I_T0_ACT |-> O_WAKE)
    else $error("timer0 wake missed");

  lv_wake_a: assert property (s_q.wake[`TCOU_LV_WAKE_BIT] && I_LV_IRQ_CFG &&
                              I_LV_ACT |-> O_WAKE)
    else $error("comparator wake missed");

  // main scenarios

  brt_ovf_c: cover property (brt_ovf && O_BRT_CLK_OE);
  t0_edge_c: cover property (I_T0_COUNTER_MODE && O_T0_COUNT_EN);
  wake_c: cover property (O_WAKE);
  rd_c: cover property (I_READ && !O_WAITREQUEST);

endmodule
`default_nettype wire

/* sim/tb_timer_clock_output_unit.sv */
`timescale 1ns/1ps
`default_nettype none
`include "tcou_regs.svh"
module tb_timer_clock_output_unit;
  logic clk, rst_n, rd, wrs, w_req, pin_run;
  logic [9:0] addr;
  logic [3:0] be;
  logic [31:0] wdat, rdat;
  logic [1:0] ovf, cmode, pins;
  logic [4:0] act, cfg;
  logic [15:0] xaddr;
  logic t0en, t1en, stick, btick, dbl, bovf, onc, offc, wake;
  logic [5:0] clk_o;
  logic [5:0] sv;
  logic [7:0] a, w, r, q;
  int n_errors = 0;
  int checks = 0;
  int cyc = 0;
  int seed = 32'hfb644f45;
  // ---------------------------------------------------------------
  // design and pulse taps
  // ---------------------------------------------------------------
  tcou_top dut_u (.I_CORE_CLK(clk), .I_RST_N(rst_n), .I_ADDRESS(addr), .I_READ(rd),
    .I_WRITE(wrs), .I_BYTEENABLE(be), .I_WRITEDATA(wdat), .O_READDATA(rdat),
    .O_WAITREQUEST(w_req), .I_T0_OVF(ovf[0]), .I_T1_OVF(ovf[1]),
    .I_T0_COUNTER_MODE(cmode[0]), .I_T1_COUNTER_MODE(cmode[1]), .I_T0_PIN(pins[0]),
    .I_T1_PIN(pins[1]), .O_T0_COUNT_EN(t0en), .O_T1_COUNT_EN(t1en),
    .O_UART1_SHIFT_TICK(stick), .O_UART1_BAUD_TICK(btick), .O_UART2_RATE_DOUBLE(dbl),
    .O_BRT_OVF(bovf), .I_XRAM_ADDR(xaddr), .O_XRAM_ONCHIP(onc), .O_XRAM_OFFCHIP(offc),
    .I_CAP_ACT(act[4]), .I_CAP_IRQ_CFG(cfg[4]), .I_RXD_ACT(act[3]), .I_RXD_IRQ_CFG(cfg[3]),
    .I_T1_ACT(act[2]), .I_T1_IRQ_CFG(cfg[2]), .I_T0_ACT(act[1]), .I_T0_IRQ_CFG(cfg[1]),
    .I_LV_ACT(act[0]), .I_LV_IRQ_CFG(cfg[0]), .O_WAKE(wake), .O_T0_CLK_OUT(clk_o[0]),
    .O_T0_CLK_OE(clk_o[1]), .O_T1_CLK_OUT(clk_o[2]), .O_T1_CLK_OE(clk_o[3]),
    .O_BRT_CLK_OUT(clk_o[4]), .O_BRT_CLK_OE(clk_o[5]));
  assign sv = {clk_o[4], bovf, stick, t1en, t0en, btick};
  // ---------------------------------------------------------------
  // clock, pin stimulus and hang guard
  // ---------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // pins run as a counter: t0 pin falls every 2 cycles, t1 every 4
  always @(posedge clk) begin
    if (pin_run) pins <= pins + 2'h1;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_errors++;
      give_verdict();
    end
  end
  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task give_verdict();
    if (n_errors == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      $display("Error %s expected %h seen %h", nm, e, g);
      n_errors++;
    end
  endtask
  // one bus cycle; request held until waitrequest is seen low
  task bus(input logic wr, input logic [9:0] ad, input logic [7:0] d, input logic [3:0] b);
    @(posedge clk);
    addr <= ad;
    wdat <= {24'h0, d};
    be <= b;
    rd <= !wr;
    wrs <= wr;
    // waitrequest and read data are taken at the rising edge itself
    do @(posedge clk); while (w_req !== 1'b0);
    q = rdat[7:0];
    rd <= 1'b0;
    wrs <= 1'b0;
  endtask
  task wr(input logic [7:0] i, input logic [7:0] d);
    bus(1'b1, {i, 2'b00}, d, 4'hF);
  endtask
  task rdc(input logic [7:0] i, input logic [7:0] e, input string nm);
    bus(1'b0, {i, 2'b00}, 8'h00, 4'hF);
    chk(nm, e, q);
  endtask
  // counts high samples of one tap over n cycles
  task cnt(input int idx, input int n, input int e, input string nm);
    int c;
    c = 0;
    repeat (n) begin
      @(negedge clk);
      c += sv[idx];
    end
    chk(nm, e, c);
  endtask
  task pulse(input int ch);
    @(posedge clk);
    ovf[ch] <= 1'b1;
    @(negedge clk);
    if (ch == 1) chk("baud tick", 1, btick);
    @(posedge clk);
    ovf[ch] <= 1'b0;
    @(negedge clk);
  endtask
  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    {rst_n, rd, wrs, pin_run, addr, be, wdat, ovf, cmode, pins, act, cfg, xaddr} = '0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    rdc(`TCOU_AUX_IDX, 8'h00, "aux reset");
    rdc(`TCOU_WAKE_IDX, 8'h00, "wake reset");
    rdc(`TCOU_RELOAD_IDX, 8'h00, "reload reset");
    for (int ch = 0; ch < 2; ch++) begin
      wr(`TCOU_WAKE_IDX, 8'h01 << ch);
      pulse(ch);
      chk("clock out", 2'b11, clk_o[2*ch +: 2]);
      wr(`TCOU_WAKE_IDX, 8'h00);
      pulse(ch);
      chk("clock out off", 2'b01, clk_o[2*ch +: 2]);
    end
    wr(`TCOU_AUX_IDX, 8'hE0);
    cnt(1, 24, 24, "t0 fast");
    cnt(2, 24, 24, "t1 fast");
    cnt(3, 24, 12, "shift fast");
    wr(`TCOU_AUX_IDX, 8'h00);
    cnt(1, 24, 2, "t0 slow");
    cnt(2, 24, 2, "t1 slow");
    cnt(3, 24, 2, "shift slow");
    cmode <= 2'b11;
    pin_run <= 1'b1;
    cnt(1, 24, 12, "t0 pin count");
    cnt(2, 24, 6, "t1 pin count");
    // baud timer: reload FC gives 4 ticks per overflow
    wr(`TCOU_RELOAD_IDX, 8'hFC);
    wr(`TCOU_WAKE_IDX, 8'h04);
    wr(`TCOU_AUX_IDX, 8'h15);
    repeat (300) @(posedge clk);
    cnt(4, 40, 10, "baud ovf fast");
    cnt(0, 40, 10, "uart1 baud tick");
    cnt(5, 40, 20, "baud clock high");
    wr(`TCOU_AUX_IDX, 8'h11);
    repeat (60) @(posedge clk);
    cnt(4, 480, 10, "baud ovf slow");
    wr(`TCOU_AUX_IDX, 8'h01);
    cnt(4, 300, 0, "baud stopped");
    for (int i = 0; i < 9; i++) begin
      a = $random(seed);
      w = $random(seed);
      r = $random(seed);
      @(posedge clk);
      act <= $random(seed);
      cfg <= $random(seed);
      xaddr <= (i % 3 == 0) ? 16'h03FF : (i % 3 == 1) ? 16'h0400 : 16'($random(seed));
      wr(`TCOU_AUX_IDX, a);
      wr(`TCOU_WAKE_IDX, w);
      wr(`TCOU_RELOAD_IDX, r);
      bus(1'b1, {`TCOU_AUX_IDX, 2'b00}, ~a, 4'hE);
      bus(1'b1, 10'h240, 8'hFF, 4'hF);
      rdc(8'h90, 8'h00, "unmapped read");
      rdc(`TCOU_AUX_IDX, a, "aux readback");
      rdc(`TCOU_WAKE_IDX, w, "wake readback");
      rdc(`TCOU_RELOAD_IDX, r, "reload readback");
      @(negedge clk);
      chk("rate double", a[3], dbl);
      chk("xram onchip", !a[1] && xaddr <= 16'h03FF, onc);
      chk("xram offchip", !(!a[1] && xaddr <= 16'h03FF), offc);
      chk("wake", |(w[7:3] & act & cfg), wake);
      chk("clock enables", w[2:0], {clk_o[5], clk_o[3], clk_o[1]});
    end
    for (int k = 0; k < 5; k++) begin
      wr(`TCOU_WAKE_IDX, 8'h08 << k);
      act <= 5'h1F;
      cfg <= ~(5'h01 << k);
      @(negedge clk);
      chk("wake unconfigured", 0, wake);
      @(posedge clk);
      cfg <= 5'h1F;
      @(negedge clk);
      chk("wake source", 1, wake);
    end
    give_verdict();
  end
endmodule
`default_nettype wire
